// *** hdl/fswt_defs.svh ***
// Register offsets, reset values, limits and timing counts of the sweep and trigger controller.
// Assumes a 50 MHz bus clock; frequencies are in units of 10 mHz, sweep time in ms.
`ifndef FSWT_DEFS_SVH
`define FSWT_DEFS_SVH
`define FSWT_A_CTRL 8'h00
`define FSWT_A_START 8'h04
`define FSWT_A_STOP 8'h08
`define FSWT_A_TIME 8'h0C
`define FSWT_A_POINTS 8'h10
`define FSWT_A_CMD 8'h14
`define FSWT_A_STATUS 8'h18
`define FSWT_A_FREQ 8'h1C
`define FSWT_CMD_RST 0
`define FSWT_CMD_APPLY 1
`define FSWT_CMD_BUS 2
`define FSWT_CMD_MAN 3
`define FSWT_F_MIN 32'h0000_0001
`define FSWT_F_MAX 32'h5968_2F00
`define FSWT_F_MAX_TRI 32'h0098_9680
`define FSWT_F_MAX_ARB8K 32'h1DCD_6500
`define FSWT_F_MAX_ARB12K 32'h0EE6_B280
`define FSWT_F_MAX_ARBBIG 32'h0131_2D00
`define FSWT_PTS_8K 16'h2000
`define FSWT_PTS_12K 16'h2FFF
`define FSWT_RST_START 32'h0000_2710
`define FSWT_RST_STOP 32'h0001_86A0
`define FSWT_RST_TIME 32'h0000_03E8
`define FSWT_RST_POINTS 16'h2000
`define FSWT_T_MIN_MS 32'h0000_0001
`define FSWT_T_MAX_MS 32'h0007_A120
`define FSWT_CLK_HZ 36'h0_02FA_F080
`define FSWT_CYC_PER_MS (`FSWT_CLK_HZ / 36'h0_0000_03E8)
`endif

// *** hdl/fswt_pkg.sv ***
// Types shared by the sweep and trigger controller.
// Frequencies are 10 mHz units; log values are 5.16 fixed point base two.
package fswt_pkg;
	typedef enum logic [2:0] {MOD_NONE, MOD_AM, MOD_FM, MOD_FSK, MOD_BURST, MOD_SWEEP} fswt_mode_t;
	typedef enum logic [1:0] {TRIG_INT, TRIG_SINGLE, TRIG_EXT, TRIG_BUS} fswt_trig_t;
	typedef enum logic [2:0] {SH_SINE, SH_SQUARE, SH_TRI, SH_RAMP, SH_ARB} fswt_shape_t;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_AT_STOP} fswt_state_t;
	// Parameters latched when a sweep starts from idle; internal-source repeats reuse them.
	typedef struct packed {
		logic [31:0] s;
		logic [31:0] d;
		logic [20:0] ls;
		logic [20:0] ld;
		logic down;
		logic lg;
		logic sh12;
		logic [23:0] ivl;
	} fswt_sweep_t;
endpackage

// *** hdl/fswt_ctrl.sv ***
// Frequency sweep and trigger controller with an AHB-Lite register slave.
// Assumes one AHB-Lite master, single word transfers, and asynchronous pin inputs.
//
// Notes on behaviour
// - One modulation mode field; selecting sweep replaces any previous mode.
// - Sweep runs start to stop, then returns to start.
// - Endpoints clamped to 10 mHz..15 MHz, 100 kHz for triangle and ramp.
// - Phase accumulator never resets on step boundaries.
// - Default start 100 Hz, stop 1 kHz.
// - Reset command sets start to minimum and stop to maximum.
// - Arbitrary shape caps endpoints at 5 MHz, 2.5 MHz or 200 kHz by points.
// - Start above stop sweeps down, below sweeps up.
// - Sync low at sweep start, high when stop frequency reached.
// - Sweep time 1 ms to 500 s, default one second.
// - Step count 2048 or 4096, chosen from the sweep time.
// - Linear or logarithmic spacing, linear by default.
// - Triggered source gives one sweep per trigger then holds start.
// - Internal source repeats sweeps with no trigger.
// - External rising edge starts one sweep or one burst.
// - Single source accepts both manual and external triggers.
// - Trigger-wait flag high while armed and waiting.
// - Manual trigger ignored in remote or outside burst and sweep.
// - Trigger source returns to internal on reset or apply command.
// - Bus source starts one sweep per bus trigger command.
// - External FREQUENCY_SHIFT_KEYING: input low selects carrier, high selects hop.
// - Gated burst: input high enables output, low disables it.
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "fswt_defs.svh"
module fswt_ctrl (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Shared external trigger, frequency_shift_keying and gate input.
	input wire logic ext_in,
	// Generator controls.
	output logic [31:0] freq_word,
	output logic [31:0] phase,
	output logic sync_out,
	output logic trig_wait,
	output logic sweeping,
	output logic burst_fire,
	output logic hop_select,
	output logic out_enable
);
	// Clamp a frequency to the limits of the present shape.
	function automatic logic [31:0] clamp_f(input logic [31:0] v, input fswt_pkg::fswt_shape_t sh,
			input logic [15:0] pts);
		logic [31:0] lim;
		lim = `FSWT_F_MAX;
		if (sh == fswt_pkg::SH_TRI || sh == fswt_pkg::SH_RAMP) begin
			lim = `FSWT_F_MAX_TRI;
		end else if (sh == fswt_pkg::SH_ARB) begin
			if (pts <= `FSWT_PTS_8K) begin
				lim = `FSWT_F_MAX_ARB8K;
			end else if (pts <= `FSWT_PTS_12K) begin
				lim = `FSWT_F_MAX_ARB12K;
			end else begin
				lim = `FSWT_F_MAX_ARBBIG;
			end
		end
		if (v < `FSWT_F_MIN) begin
			clamp_f = `FSWT_F_MIN;
		end else if (v > lim) begin
			clamp_f = lim;
		end else begin
			clamp_f = v;
		end
	endfunction

	// Base-two log with a linear mantissa; coarse, but monotonic.
	function automatic logic [20:0] log2_f(input logic [31:0] v);
		logic [4:0] p;
		logic [30:0] n;
		p = 5'd0;
		for (int i = 0; i < 31; i++) begin
			if (v[i]) begin
				p = 5'(i);
			end
		end
		n = v[30:0] << (5'd30 - p);
		log2_f = {p, n[29:14]};
	endfunction

	// Inverse of log2_f.
	function automatic logic [31:0] exp2_f(input logic [20:0] l);
		logic [47:0] t;
		t = {31'd0, 1'b1, l[15:0]} << l[20:16];
		exp2_f = {1'b0, t[46:16]};
	endfunction

	// Absolute difference, used for both linear and log spans.
	function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// Software-visible state.
	fswt_pkg::fswt_mode_t mode;
	fswt_pkg::fswt_trig_t src;
	fswt_pkg::fswt_shape_t shape;
	fswt_pkg::fswt_state_t state;
	fswt_pkg::fswt_sweep_t sw;
	logic log_sp;
	logic fsk_ext;
	logic gated;
	logic remote;
	logic [31:0] start_f;
	logic [31:0] stop_f;
	logic [31:0] time_ms;
	logic [15:0] points;
	// Bus data-phase state.
	logic pend;
	logic p_write;
	logic [7:0] p_addr;
	// Engine state.
	logic [12:0] step;
	logic [23:0] cnt;
	logic [43:0] acc;
	logic [33:0] lacc;
	// External input synchroniser.
	logic ext_meta;
	logic ext_sync;
	logic ext_last;

	// Bus decode; every access takes one wait state so reads see prior writes.
	wire addr_ok = hsel && htrans[1] && hready;
	wire do_wr = pend && p_write;
	wire do_rd = pend && !p_write;
	wire wr_ctrl = do_wr && p_addr == `FSWT_A_CTRL;
	wire wr_start = do_wr && p_addr == `FSWT_A_START;
	wire wr_stop = do_wr && p_addr == `FSWT_A_STOP;
	wire wr_time = do_wr && p_addr == `FSWT_A_TIME;
	wire wr_pts = do_wr && p_addr == `FSWT_A_POINTS;
	wire wr_cmd = do_wr && p_addr == `FSWT_A_CMD;
	wire cmd_rst = wr_cmd && hwdata[`FSWT_CMD_RST];
	wire cmd_apply = wr_cmd && hwdata[`FSWT_CMD_APPLY];
	wire cmd_bus = wr_cmd && hwdata[`FSWT_CMD_BUS];
	wire cmd_man = wr_cmd && hwdata[`FSWT_CMD_MAN];

	// Effective endpoints follow shape changes without rewriting them.
	wire [31:0] eff_start = clamp_f(start_f, shape, points);
	wire [31:0] eff_stop = clamp_f(stop_f, shape, points);
	wire sweep_on = mode == fswt_pkg::MOD_SWEEP;
	wire burst_on = mode == fswt_pkg::MOD_BURST;

	// Trigger qualification.
	wire ext_rise = ext_sync && !ext_last;
	wire ext_armed = src == fswt_pkg::TRIG_EXT || src == fswt_pkg::TRIG_SINGLE;
	wire man_ok = cmd_man && src == fswt_pkg::TRIG_SINGLE && !remote && (sweep_on || burst_on);
	wire bus_ok = cmd_bus && src == fswt_pkg::TRIG_BUS;
	wire trig_evt = (ext_armed && ext_rise) || man_ok || bus_ok;
	wire idle = state == fswt_pkg::ST_IDLE;
	wire go = sweep_on && idle && (src == fswt_pkg::TRIG_INT || trig_evt);

	// Sweep set-up, latched at each start from idle.
	wire [35:0] tot_cyc = 36'(time_ms) * `FSWT_CYC_PER_MS;
	wire use12 = time_ms > `FSWT_T_MIN_MS;
	wire [20:0] l_st = log2_f(eff_start);
	wire [20:0] l_sp = log2_f(eff_stop);
	fswt_pkg::fswt_sweep_t next_sw;
	assign next_sw.s = eff_start;
	assign next_sw.d = absdiff(eff_start, eff_stop);
	assign next_sw.ls = l_st;
	assign next_sw.ld = 21'(absdiff({11'd0, l_st}, {11'd0, l_sp}));
	assign next_sw.down = eff_start > eff_stop;
	assign next_sw.lg = log_sp;
	assign next_sw.sh12 = use12;
	assign next_sw.ivl = use12 ? 24'(tot_cyc >> 12) : 24'(tot_cyc >> 11);

	// Per-step frequency, linear or log domain.
	wire [43:0] next_acc = acc + 44'(sw.d);
	wire [33:0] next_lacc = lacc + 34'(sw.ld);
	wire [31:0] lin_off = sw.sh12 ? next_acc[43:12] : next_acc[42:11];
	wire [20:0] log_off = sw.sh12 ? next_lacc[32:12] : next_lacc[31:11];
	wire [31:0] lin_f = sw.down ? sw.s - lin_off : sw.s + lin_off;
	wire [20:0] log_v = sw.down ? sw.ls - log_off : sw.ls + log_off;
	wire [31:0] step_f = sw.lg ? exp2_f(log_v) : lin_f;
	wire [12:0] n_steps = sw.sh12 ? 13'h1000 : 13'h0800;
	wire tick = cnt == 24'h00_0000;
	wire last = 13'(step + 13'h0001) == n_steps;

	// Read mux.
	wire [31:0] ctrl_rd = {20'd0, remote, gated, fsk_ext, shape, log_sp, src, mode};
	wire [31:0] stat_rd = {27'd0, ext_sync, sw.down, sync_out, trig_wait, sweeping};
	wire [31:0] rd_mux =
		p_addr == `FSWT_A_CTRL ? ctrl_rd :
		p_addr == `FSWT_A_START ? start_f :
		p_addr == `FSWT_A_STOP ? stop_f :
		p_addr == `FSWT_A_TIME ? time_ms :
		p_addr == `FSWT_A_POINTS ? {16'd0, points} :
		p_addr == `FSWT_A_STATUS ? stat_rd :
		p_addr == `FSWT_A_FREQ ? freq_word : 32'h0000_0000;

	// Sweep time write, clamped to its legal range.
	wire [31:0] time_in = hwdata < `FSWT_T_MIN_MS ? `FSWT_T_MIN_MS :
		hwdata > `FSWT_T_MAX_MS ? `FSWT_T_MAX_MS : hwdata;

	// Bus handshake: address phase, one wait cycle, then the answer.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend <= 1'b0;
			p_write <= 1'b0;
			p_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			pend <= addr_ok && !pend;
			hreadyout <= !(addr_ok && !pend);
			if (addr_ok && !pend) begin
				p_write <= hwrite;
				p_addr <= haddr[7:0] & 8'hFC;
			end
			if (do_rd) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Configuration registers. The mode is one field, so sweep replaces any other mode.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= fswt_pkg::MOD_NONE;
			src <= fswt_pkg::TRIG_INT;
			shape <= fswt_pkg::SH_SINE;
			log_sp <= 1'b0;
			fsk_ext <= 1'b0;
			gated <= 1'b0;
			remote <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				mode <= fswt_pkg::fswt_mode_t'(hwdata[2:0]);
				src <= fswt_pkg::fswt_trig_t'(hwdata[4:3]);
				log_sp <= hwdata[5];
				shape <= fswt_pkg::fswt_shape_t'(hwdata[8:6]);
				fsk_ext <= hwdata[9];
				gated <= hwdata[10];
				remote <= hwdata[11];
			end
			if (cmd_rst || cmd_apply) begin
				src <= fswt_pkg::TRIG_INT;
			end
		end
	end

	// Endpoints, sweep time and arbitrary point count.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_f <= `FSWT_RST_START;
			stop_f <= `FSWT_RST_STOP;
			time_ms <= `FSWT_RST_TIME;
			points <= `FSWT_RST_POINTS;
		end else begin
			if (cmd_rst) begin
				start_f <= `FSWT_F_MIN;
				stop_f <= `FSWT_F_MAX;
			end else begin
				if (wr_start) begin
					start_f <= hwdata;
				end
				if (wr_stop) begin
					stop_f <= hwdata;
				end
			end
			if (wr_time) begin
				time_ms <= time_in;
			end
			if (wr_pts) begin
				points <= hwdata[15:0];
			end
		end
	end

	// External input: two-stage synchroniser, then a delayed copy for edges.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_last <= 1'b0;
		end else begin
			ext_meta <= ext_in;
			ext_sync <= ext_meta;
			ext_last <= ext_sync;
		end
	end

	// Sweep engine. Edges seen while running are dropped, not queued.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= fswt_pkg::ST_IDLE;
			sw <= '0;
			step <= 13'h0000;
			cnt <= 24'h00_0000;
			acc <= 44'h000_0000_0000;
			lacc <= 34'h0_0000_0000;
			freq_word <= `FSWT_RST_START;
			sync_out <= 1'b0;
		end else begin
			case (state)
				fswt_pkg::ST_IDLE: begin
					freq_word <= eff_start;
					sync_out <= 1'b0;
					if (go) begin
						sw <= next_sw;
						cnt <= next_sw.ivl - 24'h00_0001;
						step <= 13'h0000;
						acc <= 44'h000_0000_0000;
						lacc <= 34'h0_0000_0000;
						state <= fswt_pkg::ST_RUN;
					end
				end
				fswt_pkg::ST_RUN: begin
					if (!sweep_on) begin
						state <= fswt_pkg::ST_IDLE;
					end else if (tick) begin
						cnt <= sw.ivl - 24'h00_0001;
						step <= step + 13'h0001;
						acc <= next_acc;
						lacc <= next_lacc;
						freq_word <= step_f;
						if (last) begin
							sync_out <= 1'b1;
							state <= fswt_pkg::ST_AT_STOP;
						end
					end else begin
						cnt <= cnt - 24'h00_0001;
					end
				end
				fswt_pkg::ST_AT_STOP: begin
					if (!sweep_on) begin
						state <= fswt_pkg::ST_IDLE;
					end else if (tick) begin
						freq_word <= sw.s;
						sync_out <= 1'b0;
						cnt <= sw.ivl - 24'h00_0001;
						step <= 13'h0000;
						acc <= 44'h000_0000_0000;
						lacc <= 34'h0_0000_0000;
						if (src == fswt_pkg::TRIG_INT) begin
							state <= fswt_pkg::ST_RUN;
						end else begin
							state <= fswt_pkg::ST_IDLE;
						end
					end else begin
						cnt <= cnt - 24'h00_0001;
					end
				end
				default: begin
					state <= fswt_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Phase accumulates the live frequency and is never cleared between steps.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= 32'h0000_0000;
		end else begin
			phase <= phase + freq_word;
		end
	end

	// Status and shared-input outputs.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_wait <= 1'b0;
			sweeping <= 1'b0;
			burst_fire <= 1'b0;
			hop_select <= 1'b0;
			out_enable <= 1'b1;
		end else begin
			trig_wait <= (sweep_on || burst_on) && src != fswt_pkg::TRIG_INT
				&& (idle || burst_on);
			sweeping <= !idle;
			burst_fire <= burst_on && !gated && trig_evt;
			hop_select <= mode == fswt_pkg::MOD_FSK && fsk_ext && ext_sync;
			out_enable <= !(burst_on && gated) || ext_sync;
		end
	end
endmodule

// *** dv/fswt_chk.sv ***
// Concurrent checks on the sweep and trigger controller's ports.
// Assumes one clock domain and the bus wired with hready tied to hreadyout.
`timescale 1ns/1ps
module fswt_chk (
	// Clock and reset.
	input logic hclk,
	input logic hresetn,
	// Bus side.
	input logic hsel,
	input logic [1:0] htrans,
	input logic hready,
	input logic hreadyout,
	input logic hresp,
	// Pin side.
	input logic ext_in,
	input logic [31:0] freq_word,
	input logic [31:0] phase,
	input logic sync_out,
	input logic sweeping,
	input logic burst_fire,
	input logic hop_select,
	input logic out_enable
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Every accepted transfer costs exactly one wait state.
	wait_state_a:
		assert property (hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
		else $error("wait state count wrong");
	resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
	phase_cont_a:
		assert property ($past(hresetn) |-> phase == $past(phase) + $past(freq_word))
		else $error("phase jumped");
	sync_high_a: assert property (sync_out |-> sweeping) else $error("sync high while idle");
	sync_start_a: assert property ($rose(sweeping) |-> !sync_out) else $error("sync high at start");
	// Latency through the synchroniser is a few edges, so a short window is allowed.
	hop_level_a:
		assert property ($rose(hop_select) |-> $past(ext_in, 2) || $past(ext_in, 3) || $past(ext_in, 4))
		else $error("hop without high input");
	gate_low_a:
		assert property ($fell(out_enable) |->
			!$past(ext_in, 2) || !$past(ext_in, 3) || !$past(ext_in, 4))
		else $error("gate closed with high input");
	burst_pulse_a: assert property (burst_fire |=> !burst_fire) else $error("burst pulse too long");
	step_hold_a:
		assert property (sweeping && $changed(freq_word) |=> ($stable(freq_word) || !sweeping)[*8])
		else $error("step too short");
	sync_cov: cover property ($rose(sync_out));
	hop_cov: cover property ($rose(hop_select));
	gate_cov: cover property ($fell(out_enable));
	fire_cov: cover property (burst_fire);
endmodule

bind fswt_ctrl fswt_chk fswt_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .ext_in(ext_in), .freq_word(freq_word),
	.phase(phase), .sync_out(sync_out), .sweeping(sweeping), .burst_fire(burst_fire),
	.hop_select(hop_select), .out_enable(out_enable));

// *** dv/fswt_ext_src.sv ***
// Model of the outside source on the shared trigger, keying and gate terminal.
// Assumes the bench selects a level or asks for one trigger pulse by cmd.
`timescale 1ns/1ps
module fswt_ext_src (
	// Clock.
	input logic hclk,
	// Request: 0 low, 1 high, 2 one pulse.
	input logic [1:0] cmd,
	// Terminal, always driven like a TTL output.
	output logic ext_in
);
	logic [2:0] cnt = 3'h0;
	initial ext_in = 1'b0;
	// A pulse holds high four cycles so that a single rising edge is seen.
	always @(posedge hclk) begin
		if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
			ext_in <= (cnt != 3'h1);
		end else if (cmd == 2'h2) begin
			ext_in <= 1'b1;
			cnt <= 3'h4;
		end else begin
			ext_in <= cmd[0];
		end
	end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the sweep and trigger controller.
// Assumes the checker is bound and the far terminal is the source model.
`timescale 1ns/1ps
`include "fswt_defs.svh"
module tb_top;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0;
	logic [1:0] htrans = 2'h0, ecmd = 2'h0;
	logic [31:0] haddr = 0, hwdata = 0, rnd = 32'h0000_461F;
	logic hreadyout, hresp, sync_out, trig_wait, sweeping, burst_fire, hop_select, out_enable, ext_in;
	logic [31:0] hrdata, freq_word, phase, f0;
	logic [31:0] exp_q[$];
	int miscompares = 0, checks = 0, c, fires = 0;
	always #10 hclk = ~hclk;
	fswt_ctrl fswt_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_in(ext_in),
		.freq_word(freq_word), .phase(phase), .sync_out(sync_out), .trig_wait(trig_wait),
		.sweeping(sweeping), .burst_fire(burst_fire), .hop_select(hop_select),
		.out_enable(out_enable));
	fswt_ext_src fswt_ext_src_inst (.hclk(hclk), .cmd(ecmd), .ext_in(ext_in));

	function logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Every wait is bounded; running out ends the run as a failure.
	task automatic wt(ref logic s, input logic v, input int lim);
		c = 0;
		while (s !== v && c < lim) begin
			@(posedge hclk);
			c++;
		end
		if (s !== v) begin
			miscompares++;
			$display("Error at %0t: wait ran out", $time);
			wrap_up();
		end
	endtask
	// One single transfer; the request is held until ready is seen high.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		wt(hreadyout, 1'b1, 20);
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= ~w;
		@(posedge hclk);
		wt(hreadyout, 1'b1, 20);
		rd_ph <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	task pulse;
		ecmd <= 2'h2;
		@(posedge hclk);
		ecmd <= 2'h0;
	endtask
	// Read data is judged against the oldest expectation when the data phase ends.
	always @(posedge hclk)
		if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0)
			check(hrdata, exp_q.pop_front(), "read data");
	// Burst pulses are counted, so a doubled or a missing pulse shows up.
	always @(posedge hclk)
		if (burst_fire === 1'b1)
			fires++;

	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`FSWT_A_CTRL, 32'h0000_0000);
		rd(`FSWT_A_START, `FSWT_RST_START);
		rd(`FSWT_A_STOP, `FSWT_RST_STOP);
		rd(`FSWT_A_TIME, `FSWT_RST_TIME);
		rd(8'h20, 32'h0000_0000);
		bus(1'b1, `FSWT_A_TIME, 32'h0000_0000);
		rd(`FSWT_A_TIME, `FSWT_T_MIN_MS);
		bus(1'b1, `FSWT_A_TIME, 32'h0009_27C0);
		rd(`FSWT_A_TIME, `FSWT_T_MAX_MS);
		// Endpoints are stored raw, but the live frequency is clamped to the shape's limit.
		bus(1'b1, `FSWT_A_START, 32'hFFFF_FFFF);
		rd(`FSWT_A_FREQ, `FSWT_F_MAX);
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0080);
		rd(`FSWT_A_FREQ, `FSWT_F_MAX_TRI);
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_00C0);
		rd(`FSWT_A_FREQ, `FSWT_F_MAX_TRI);
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0100);
		rd(`FSWT_A_FREQ, `FSWT_F_MAX_ARB8K);
		bus(1'b1, `FSWT_A_POINTS, 32'h0000_2FFF);
		rd(`FSWT_A_FREQ, `FSWT_F_MAX_ARB12K);
		bus(1'b1, `FSWT_A_POINTS, 32'h0000_3000);
		rd(`FSWT_A_FREQ, `FSWT_F_MAX_ARBBIG);
		bus(1'b1, `FSWT_A_START, 32'h0000_0000);
		rd(`FSWT_A_FREQ, `FSWT_F_MIN);
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0000);
		rnd = xs(rnd);
		bus(1'b1, `FSWT_A_START, rnd);
		rd(`FSWT_A_START, rnd);
		$display("test registers done");
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0203);
		repeat (8) begin
			rnd = xs(rnd);
			ecmd <= {1'b0, rnd[0]};
			repeat (8) @(posedge hclk);
			check(hop_select, rnd[0], "hop select");
		end
		ecmd <= 2'h1;
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0005);
		repeat (8) @(posedge hclk);
		check(hop_select, 1'b0, "hop after sweep on");
		check(sweeping, 1'b1, "free running sweep");
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0404);
		ecmd <= 2'h0;
		repeat (8) @(posedge hclk);
		check(out_enable, 1'b0, "gate low");
		ecmd <= 2'h1;
		repeat (8) @(posedge hclk);
		check(out_enable, 1'b1, "gate high");
		ecmd <= 2'h0;
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0014);
		fires = 0;
		pulse();
		repeat (6) @(posedge hclk);
		check(trig_wait, 1'b1, "burst armed");
		check(fires, 1, "one burst per edge");
		$display("test pin modes done");
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_080D);
		bus(1'b1, `FSWT_A_CMD, 32'h0000_0008);
		repeat (4) @(posedge hclk);
		check(trig_wait, 1'b1, "armed in remote");
		check(sweeping, 1'b0, "manual in remote");
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_001D);
		bus(1'b1, `FSWT_A_CMD, 32'h0000_0004);
		wt(sweeping, 1'b1, 8);
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0000);
		repeat (2) @(posedge hclk);
		check(sweeping, 1'b0, "sweep left");
		$display("test trigger sources done");
		bus(1'b1, `FSWT_A_TIME, 32'h0000_0001);
		bus(1'b1, `FSWT_A_START, `FSWT_RST_STOP);
		bus(1'b1, `FSWT_A_STOP, `FSWT_RST_START);
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_000D);
		pulse();
		wt(sweeping, 1'b1, 10);
		f0 = freq_word;
		c = 0;
		while (freq_word === f0 && c < 100) begin
			@(posedge hclk);
			c++;
		end
		check(freq_word !== f0, 1'b1, "first step");
		f0 = freq_word;
		c = 0;
		while (freq_word === f0 && c < 100) begin
			@(posedge hclk);
			c++;
		end
		check(c, 24, "step interval");
		check(freq_word < `FSWT_RST_STOP, 1'b1, "downward");
		pulse();
		wt(sync_out, 1'b1, 60000);
		check(freq_word, `FSWT_RST_START, "stop frequency at sync");
		wt(sync_out, 1'b0, 40);
		check(freq_word, `FSWT_RST_STOP, "back to start");
		repeat (8) @(posedge hclk);
		check(sweeping, 1'b0, "one sweep only");
		check(trig_wait, 1'b1, "armed again");
		$display("test triggered sweep done");
		// A log sweep upward starts slower than a linear one, so its first step is smaller.
		bus(1'b1, `FSWT_A_START, `FSWT_RST_START);
		bus(1'b1, `FSWT_A_STOP, `FSWT_RST_STOP);
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0035);
		pulse();
		wt(sweeping, 1'b1, 10);
		f0 = freq_word;
		c = 0;
		while (freq_word === f0 && c < 100) begin
			@(posedge hclk);
			c++;
		end
		f0 = `FSWT_RST_START + ((`FSWT_RST_STOP - `FSWT_RST_START) >> 11);
		check(freq_word > `FSWT_RST_START, 1'b1, "log step up");
		check(freq_word < f0, 1'b1, "log step slow");
		$display("test log sweep done");
		bus(1'b1, `FSWT_A_CMD, 32'h0000_0001);
		rd(`FSWT_A_START, `FSWT_F_MIN);
		rd(`FSWT_A_STOP, `FSWT_F_MAX);
		bus(1'b1, `FSWT_A_CTRL, 32'h0000_0015);
		bus(1'b1, `FSWT_A_CMD, 32'h0000_0002);
		rd(`FSWT_A_CTRL, 32'h0000_0005);
		$display("test commands done");
		wrap_up();
	end
endmodule
